//--- rtl/err_count_map.svh
`ifndef ERR_COUNT_MAP_SVH
`define ERR_COUNT_MAP_SVH

// Register indexes; the bus byte address is four times the index
`define LINE_HIGH_INDEX 8'h23
`define LINE_LOW_INDEX 8'h24
`define SHARED_HIGH_INDEX 8'h25
`define PATH_LOW_INDEX 8'h26
`define SYNC_LOW_INDEX 8'h27
`define CONTROL_INDEX 8'h30
`define INT_STATUS_INDEX 8'h31
`define INT_MASK_INDEX 8'h32

// Control register fields
`define CTRL_INTERVAL_SEL 0
`define CTRL_B8ZS 1
`define CTRL_ESF 2
`define CTRL_EXZ 3
`define CTRL_FS 4
`define CTRL_SYNC_MODE 5
`define CTRL_WIDTH 6

// Interrupt status fields
`define INT_INTERVAL 0
`define INT_WIDTH 1

// Reset values
`define CONTROL_RESET 6'h00
`define INT_MASK_RESET 1'h0

// Interval timing
`define CLOCK_HZ 100000000
`define LONG_INTERVAL_MS 1000
`define SHORT_INTERVAL_MS 42
`define LONG_INTERVAL_CYCLES (`CLOCK_HZ / 1000 * `LONG_INTERVAL_MS)
`define SHORT_INTERVAL_CYCLES (`CLOCK_HZ / 1000 * `SHORT_INTERVAL_MS)

// Zero-run lengths counted as excessive zeros
`define ZERO_RUN_PLAIN 16
`define ZERO_RUN_B8ZS 8

`endif

//--- rtl/err_count_pkg.sv
`default_nettype none
package err_count_pkg;

  // Register picked by a bus address; none covers every refused address
  typedef enum logic [3:0] {
    sel_none,
    sel_line_high,
    sel_line_low,
    sel_shared_high,
    sel_path_low,
    sel_sync_low,
    sel_control,
    sel_int_status,
    sel_int_mask
  } reg_sel_type;

  typedef logic [15:0] line_count_type;
  typedef logic [11:0] short_count_type;

endpackage
`default_nettype wire

//--- rtl/t1_receive_error_counters.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "err_count_map.svh"

// Summary of operation
// - All three counts are copied to their readable registers at every interval boundary, one second or 42 ms as the interval select bit picks.
// - Each running counter saturates at its maximum and holds until the next interval restarts it.
// - The line count is 16 bits, high byte at 0x23 and low byte at 0x24.
// - The line counter counts even while receive sync is lost.
// - The line counter counts bipolar violations, excluding B8ZS words when B8ZS is on, plus zero runs of 16 (or 8 with B8ZS) when enabled.
// - The path counter is 12 bits and counts CRC6 errors in ESF or Ft errors in D4.
// - In D4 the Fs option adds Fs errors to the path count; ESF ignores it.
// - The path counter stops while receive sync is lost.
// - Path count bits 11..8 sit in the low nibble of 0x25 and bits 7..0 at 0x26.
// - With sync mode 1 the third counter counts out-of-sync multiframes, even during sync loss.
// - With sync mode 0 the third counter counts Ft (D4) or FPS (ESF) errors and stops during sync loss.
// - The third count is 12 bits, bits 11..8 in the high nibble of 0x25 and bits 7..0 at 0x27.
module t1_receive_error_counters #(
  parameter int unsigned LONG_CYCLES = `LONG_INTERVAL_CYCLES,
  parameter int unsigned SHORT_CYCLES = `SHORT_INTERVAL_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive framer events, one-cycle pulses; receive_sync_lost is a level
  input wire logic bipolar_violation,
  input wire logic b8zs_code_word,
  input wire logic zero_bit,
  input wire logic one_bit,
  input wire logic crc6_error,
  input wire logic ft_error,
  input wire logic fs_error,
  input wire logic fps_error,
  input wire logic multiframe_out_of_sync,
  input wire logic receive_sync_lost,
  // Interval and interrupt
  output logic interval_timer_flag,
  output logic irq
);

  logic [`CTRL_WIDTH-1:0] control;
  logic [`INT_WIDTH-1:0] int_status;
  logic [`INT_WIDTH-1:0] int_mask;
  logic [31:0] timer;
  logic boundary;
  logic [4:0] zero_run;
  logic zero_event;
  logic line_event;
  logic path_event;
  logic sync_event;
  err_count_pkg::line_count_type line_run;
  err_count_pkg::line_count_type line_latched;
  err_count_pkg::short_count_type path_run;
  err_count_pkg::short_count_type path_latched;
  err_count_pkg::short_count_type sync_run;
  err_count_pkg::short_count_type sync_latched;
  err_count_pkg::reg_sel_type sel;
  logic setup;
  logic do_write;
  logic write_ok;
  logic do_read;
  logic [31:0] next_rdata;
  logic next_err;

  function automatic logic [31:0] sat_add(input logic [31:0] value,
                                          input logic [31:0] limit,
                                          input logic event_in);
    if (event_in && value < limit) begin
      sat_add = value + 32'h1;
    end else begin
      sat_add = value;
    end
  endfunction

  // One decode serves the read mux and every write enable
  function automatic err_count_pkg::reg_sel_type reg_select(
      input logic [11:0] addr);
    if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00) begin
      reg_select = err_count_pkg::sel_none;
    end else if (addr[9:2] == `LINE_HIGH_INDEX) begin
      reg_select = err_count_pkg::sel_line_high;
    end else if (addr[9:2] == `LINE_LOW_INDEX) begin
      reg_select = err_count_pkg::sel_line_low;
    end else if (addr[9:2] == `SHARED_HIGH_INDEX) begin
      reg_select = err_count_pkg::sel_shared_high;
    end else if (addr[9:2] == `PATH_LOW_INDEX) begin
      reg_select = err_count_pkg::sel_path_low;
    end else if (addr[9:2] == `SYNC_LOW_INDEX) begin
      reg_select = err_count_pkg::sel_sync_low;
    end else if (addr[9:2] == `CONTROL_INDEX) begin
      reg_select = err_count_pkg::sel_control;
    end else if (addr[9:2] == `INT_STATUS_INDEX) begin
      reg_select = err_count_pkg::sel_int_status;
    end else if (addr[9:2] == `INT_MASK_INDEX) begin
      reg_select = err_count_pkg::sel_int_mask;
    end else begin
      reg_select = err_count_pkg::sel_none;
    end
  endfunction

  // Interval timer
  wire logic [31:0] limit = control[`CTRL_INTERVAL_SEL] ?
    SHORT_CYCLES - 1 : LONG_CYCLES - 1;
  assign boundary = (timer >= limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= 32'h0;
    end else if (boundary) begin
      timer <= 32'h0;
    end else begin
      timer <= timer + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_timer_flag <= 1'b0;
    end else begin
      interval_timer_flag <= boundary;
    end
  end

  // Excessive-zero run detector; one event per completed run. A control
  // write restarts the run so a partial run never fires under a new length.
  wire logic [4:0] run_len = control[`CTRL_B8ZS] ?
    5'(`ZERO_RUN_B8ZS) : 5'(`ZERO_RUN_PLAIN);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_run <= 5'h00;
    end else if (write_ok && sel == err_count_pkg::sel_control) begin
      zero_run <= 5'h00;
    end else if (one_bit) begin
      zero_run <= 5'h00;
    end else if (zero_bit) begin
      if (zero_run + 5'h01 >= run_len) begin
        zero_run <= 5'h00;
      end else begin
        zero_run <= zero_run + 5'h01;
      end
    end
  end
  assign zero_event = control[`CTRL_EXZ] && zero_bit && !one_bit &&
    (zero_run + 5'h01 >= run_len);

  // B8ZS substitution words are not violations when B8ZS is on
  assign line_event = (bipolar_violation &&
    !(control[`CTRL_B8ZS] && b8zs_code_word)) || zero_event;

  assign path_event = !receive_sync_lost &&
    (control[`CTRL_ESF] ? crc6_error :
     (ft_error || (control[`CTRL_FS] && fs_error)));

  assign sync_event = control[`CTRL_SYNC_MODE] ?
    multiframe_out_of_sync :
    (!receive_sync_lost &&
     (control[`CTRL_ESF] ? fps_error : ft_error));

  // Running counters restart on the boundary; a same-cycle event opens the
  // new interval so nothing is lost or counted twice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_run <= 16'h0000;
    end else if (boundary) begin
      line_run <= {15'h0000, line_event};
    end else begin
      line_run <= 16'(sat_add({16'h0000, line_run}, 32'hffff,
                              line_event));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      path_run <= 12'h000;
    end else if (boundary) begin
      path_run <= {11'h000, path_event};
    end else begin
      path_run <= 12'(sat_add({20'h00000, path_run}, 32'hfff,
                              path_event));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_run <= 12'h000;
    end else if (boundary) begin
      sync_run <= {11'h000, sync_event};
    end else begin
      sync_run <= 12'(sat_add({20'h00000, sync_run}, 32'hfff,
                              sync_event));
    end
  end

  // Latched copies hold the previous interval until the next boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_latched <= 16'h0000;
    end else if (boundary) begin
      line_latched <= line_run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      path_latched <= 12'h000;
    end else if (boundary) begin
      path_latched <= path_run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_latched <= 12'h000;
    end else if (boundary) begin
      sync_latched <= sync_run;
    end
  end

  // APB decode: zero-wait, answered in the first access cycle
  assign sel = reg_select(paddr);
  assign setup = psel && !penable;
  assign do_write = psel && penable && pwrite && pready;
  assign do_read = setup && !pwrite;
  assign write_ok = do_write && !pslverr;

  // The line count takes two transfers; software that straddles a boundary
  // gets its two bytes from different intervals
  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    case (sel)
      err_count_pkg::sel_line_high: begin
        next_rdata = {24'h0, line_latched[15:8]};
        next_err = pwrite;
      end
      err_count_pkg::sel_line_low: begin
        next_rdata = {24'h0, line_latched[7:0]};
        next_err = pwrite;
      end
      err_count_pkg::sel_shared_high: begin
        next_rdata = {24'h0, sync_latched[11:8],
                      path_latched[11:8]};
        next_err = pwrite;
      end
      err_count_pkg::sel_path_low: begin
        next_rdata = {24'h0, path_latched[7:0]};
        next_err = pwrite;
      end
      err_count_pkg::sel_sync_low: begin
        next_rdata = {24'h0, sync_latched[7:0]};
        next_err = pwrite;
      end
      err_count_pkg::sel_control: begin
        next_rdata = {26'h0, control};
      end
      err_count_pkg::sel_int_status: begin
        next_rdata = {31'h0, int_status};
      end
      err_count_pkg::sel_int_mask: begin
        next_rdata = {31'h0, int_mask};
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // pready is registered from the setup cycle so the access phase completes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && next_err;
    end
  end

  // Read data holds until the next read, not only for the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (do_read) begin
      prdata <= next_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `CONTROL_RESET;
    end else if (write_ok && sel == err_count_pkg::sel_control) begin
      control <= pwdata[`CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask <= `INT_MASK_RESET;
    end else if (write_ok && sel == err_count_pkg::sel_int_mask) begin
      int_mask <= pwdata[`INT_WIDTH-1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= 1'b0;
    end else if (boundary) begin
      int_status[`INT_INTERVAL] <= 1'b1;
    end else if (write_ok && sel == err_count_pkg::sel_int_status &&
                 pwdata[`INT_INTERVAL]) begin
      int_status[`INT_INTERVAL] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

endmodule

`default_nettype wire

//--- dv/t1_rx_err_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module t1_rx_err_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interval
  input wire logic interval_timer_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup;
    psel && !penable;
  endsequence
  sequence count_area;
    paddr >= 12'h08c && paddr <= 12'h09c && paddr[1:0] == 2'b00;
  endsequence
  chk_ready_next: assert property (setup |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_idle_quiet: assert property (!psel |=> !pready)
    else $error("ready without select");
  chk_err_paired: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_ro_refused: assert property (
    setup ##0 count_area ##0 pwrite |=> pslverr)
    else $error("count write accepted");
  chk_read_ok: assert property (
    setup ##0 count_area ##0 !pwrite |=> pready && !pslverr)
    else $error("count read refused");
  chk_high_refused: assert property (
    setup ##0 paddr[11:10] != 2'b00 |=> pslverr)
    else $error("high address accepted");
  chk_byte_wide: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data above byte");
  chk_flag_pulse: assert property (
    $rose(interval_timer_flag) |=> !interval_timer_flag [*8])
    else $error("interval flag too long or too soon");
endmodule
`default_nettype wire

//--- dv/t1_receive_error_counters_tb.sv
`timescale 1ns/10ps
`default_nettype none
module t1_receive_error_counters_tb;
  // Short enough to saturate a 12-bit count in one long interval
  localparam int LONG = 5000;
  localparam int SHORT = 60;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, los = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, interval_timer_flag, irq, err;
  logic [8:0] ev = 9'h000;
  int fails = 0, checked = 0;
  t1_receive_error_counters #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bipolar_violation(ev[0]), .b8zs_code_word(ev[1]),
    .zero_bit(ev[2]), .one_bit(ev[3]), .crc6_error(ev[4]), .ft_error(ev[5]),
    .fs_error(ev[6]), .fps_error(ev[7]), .multiframe_out_of_sync(ev[8]),
    .receive_sync_lost(los), .interval_timer_flag, .irq);
  always #5 pclk = ~pclk;
  task check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task wait_flag;
    do begin
      @(posedge pclk);
    end while (interval_timer_flag !== 1'b1);
  endtask
  // Events are driven for k cycles inside one interval; reads finish well before the next one
  task interval(input logic [5:0] c, input logic [8:0] v, input int k,
      input logic l, input logic [15:0] el, input logic [11:0] ep, es);
    xfer(1'b1, 12'h0c0, {26'h0, c});
    wait_flag;
    los <= l;
    ev <= v;
    repeat (k) @(posedge pclk);
    ev <= 9'h000;
    los <= 1'b0;
    wait_flag;
    rchk(12'h08c, el[15:8]);
    rchk(12'h090, el[7:0]);
    rchk(12'h094, {es[11:8], ep[11:8]});
    rchk(12'h098, ep[7:0]);
    rchk(12'h09c, es[7:0]);
  endtask
  task s_regs;
    rchk(12'h0c0, 32'h0);
    rchk(12'h08c, 32'h0);
    xfer(1'b1, 12'h08c, 32'h5a);
    check(err, 1'b1);
    xfer(1'b0, 12'h400, 32'h0);
    check(err, 1'b1);
    xfer(1'b0, 12'h0c2, 32'h0);
    check(err, 1'b1);
    xfer(1'b0, 12'h0a0, 32'h0);
    check(err, 1'b1);
    xfer(1'b1, 12'h0c0, 32'h2a);
    rchk(12'h0c0, 32'h2a);
    check(err, 1'b0);
  endtask
  task s_line;
    interval(6'h01, 9'h001, 5, 1'b1, 16'd5, 12'd0, 12'd0);
    interval(6'h03, 9'h003, 4, 1'b0, 16'd0, 12'd0, 12'd0);
    interval(6'h09, 9'h004, 33, 1'b0, 16'd2, 12'd0, 12'd0);
    interval(6'h0b, 9'h004, 17, 1'b0, 16'd2, 12'd0, 12'd0);
  endtask
  task s_path;
    interval(6'h01, 9'h1f0, 3, 1'b0, 16'd0, 12'd3, 12'd3);
    interval(6'h11, 9'h040, 3, 1'b0, 16'd0, 12'd3, 12'd0);
    interval(6'h15, 9'h0e0, 4, 1'b0, 16'd0, 12'd0, 12'd4);
    interval(6'h05, 9'h110, 4, 1'b0, 16'd0, 12'd4, 12'd0);
  endtask
  task s_sync;
    interval(6'h21, 9'h120, 3, 1'b1, 16'd0, 12'd0, 12'd3);
    interval(6'h25, 9'h100, 2, 1'b0, 16'd0, 12'd0, 12'd2);
    interval(6'h01, 9'h0a0, 3, 1'b1, 16'd0, 12'd0, 12'd0);
  endtask
  task s_boundary;
    ev <= 9'h001;
    wait_flag;
    wait_flag;
    rchk(12'h08c, 32'h0);
    rchk(12'h090, SHORT);
    ev <= 9'h000;
  endtask
  task s_irq;
    wait_flag;
    xfer(1'b1, 12'h0c4, 32'h1);
    xfer(1'b1, 12'h0c8, 32'h1);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0);
    wait_flag;
    repeat (3) @(posedge pclk);
    check(irq, 1'b1);
    xfer(1'b1, 12'h0c8, 32'h0);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0);
    rchk(12'h0c4, 32'h1);
    xfer(1'b1, 12'h0c4, 32'h1);
    rchk(12'h0c4, 32'h0);
  endtask
  task s_saturate;
    interval(6'h00, 9'h021, 4100, 1'b0, 16'h1004, 12'hfff, 12'hfff);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_regs;
    s_line;
    s_path;
    s_sync;
    s_boundary;
    s_irq;
    s_saturate;
    end_of_test;
  end
  // Roughly three times the expected run
  initial begin
    #400000;
    fails++;
    end_of_test;
  end
endmodule
bind t1_receive_error_counters t1_rx_err_asserts chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .interval_timer_flag);
`default_nettype wire
